// ### rtl/dpmb_defs.svh
/*
  Constants for the two-port mailbox, collision and sleep control block.
  Assumes inclusion by the package and the top module only.
*/
`ifndef DPMB_DEFS_SVH
`define DPMB_DEFS_SVH

`define DPMB_ADDR_W 18
`define DPMB_DATA_W 36
`define DPMB_MBOX_LEFT 18'h3FFFE
`define DPMB_MBOX_RIGHT 18'h3FFFF
`define DPMB_REACT_CYCLES 2'h2
`define DPMB_ALERT_DELAY 2'h2

`endif

// ### rtl/dpmb_pkg.sv
/*
  Types for the two-port mailbox, collision and sleep control block.
  Assumes the constants header is on the include path.
*/
`include "dpmb_defs.svh"

package dpmb_pkg;

  // One port's request as seen by the control logic
  typedef struct packed {
    logic primary_select_n;
    logic secondary_select;
    logic read_mode;
    logic [`DPMB_ADDR_W-1:0] address;
    logic [`DPMB_DATA_W-1:0] write_data;
  } dpmb_port_req_type;

  // One port's answer
  typedef struct packed {
    logic [`DPMB_DATA_W-1:0] read_data;
    logic read_valid;
    logic data_oe;
    logic overlap_alert_n;
    logic asleep;
  } dpmb_port_rsp_type;

  typedef enum logic [1:0] {
    DPMB_ACTIVE,
    DPMB_WAKING,
    DPMB_SLEEPING
  } dpmb_power_type;

endpackage : dpmb_pkg

// ### rtl/dpmb_mailbox.sv
/*
  Inter-port control of a two-port memory: select power-down, mailbox
  doorbells, collision alerts and sleep sequencing, with a small array.
  Assumes both port requests are synchronous to the one clock; the sleep
  requests come from pins and are synchronised here.
*/
// Summary of operation
// - Either select off one cycle powers port down
// - Outputs return after two selected cycles
// - Right write to 3FFFE raises left doorbell
// - Left selected read of 3FFFE clears it
// - Left write to 3FFFF raises right doorbell
// - Mailbox words store data like memory
// - Unused mailboxes stay plain memory
// - Both reading same address: no alert
// - Write plus read: alert on reader only
// - Both writing: alert on both ports
// - Alert low second edge, one cycle
// - Alert clears itself the next cycle
// - Back-to-back second collision may be dropped
// - Continuous collisions toggle the alert
// - Asynchronous sleep request per port
// - Asleep port deselected, outputs off, idle
// - Asleep port ignores its clock
// - Read data unsure entering sleep
// - Matching uses full port address
// - Selected means primary low, secondary high
`timescale 1ns/1ns
`default_nettype none
`include "dpmb_defs.svh"

module dpmb_mailbox #(
  parameter int ADDR_W = `DPMB_ADDR_W,
  parameter int DATA_W = `DPMB_DATA_W,
  parameter int DEPTH = 64
) (
  input wire logic clock,
  input wire logic srst,
  input wire dpmb_pkg::dpmb_port_req_type left_req,
  input wire dpmb_pkg::dpmb_port_req_type right_req,
  input wire logic left_sleep_request,
  input wire logic right_sleep_request,
  output dpmb_pkg::dpmb_port_rsp_type left_rsp,
  output dpmb_pkg::dpmb_port_rsp_type right_rsp,
  output logic left_doorbell_n,
  output logic right_doorbell_n
);
  import dpmb_pkg::*;

  initial begin
    if (ADDR_W != `DPMB_ADDR_W || DATA_W != `DPMB_DATA_W || DEPTH < 4 || DEPTH > 4096)
      $error("dpmb_mailbox: unsupported parameters");
  end

  localparam int IDX_W = $clog2(DEPTH);

  // Small array; the top two addresses map onto the top two words
  logic [DATA_W-1:0] mem [DEPTH];

  dpmb_port_req_type req [2];
  logic sleep_pin [2];
  dpmb_port_rsp_type rsp [2];
  logic [1:0] sel;
  logic [1:0] acc;
  logic [1:0] col_hit;
  logic [1:0] col_any;
  logic [1:0] sleep_sync;

  assign req[0] = left_req;
  assign req[1] = right_req;
  assign sleep_pin[0] = left_sleep_request;
  assign sleep_pin[1] = right_sleep_request;
  assign left_rsp = rsp[0];
  assign right_rsp = rsp[1];

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      logic s1;
      logic s2;
      logic [1:0] sel_run;
      dpmb_power_type power;
      logic [1:0] wake_cnt;
      logic [1:0] pend;
      logic pulse_done;

      // Two flops for the asynchronous sleep pin
      always_ff @(posedge clock) begin
        if (srst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
        end else begin
          s1 <= sleep_pin[p];
          s2 <= s1;
        end
      end
      assign sleep_sync[p] = s2;

      assign sel[p] = !req[p].primary_select_n && req[p].secondary_select;
      // Asleep port performs no access; clock effect is gated by state
      assign acc[p] = sel[p] && (power == DPMB_ACTIVE);

      always_ff @(posedge clock) begin
        if (srst) begin
          power <= DPMB_ACTIVE;
          wake_cnt <= 2'h0;
        end else begin
          case (power)
            DPMB_ACTIVE: if (s2) power <= DPMB_SLEEPING;
            DPMB_SLEEPING: if (!s2) begin
              power <= DPMB_WAKING;
              wake_cnt <= 2'h0;
            end
            DPMB_WAKING: begin
              if (s2) power <= DPMB_SLEEPING;
              else if (sel[p]) power <= DPMB_ACTIVE;
            end
            default: power <= DPMB_ACTIVE;
          endcase
        end
      end

      // Count consecutive selected cycles to reactivate outputs
      always_ff @(posedge clock) begin
        if (srst) begin
          sel_run <= 2'h0;
        end else if (!acc[p]) begin
          sel_run <= 2'h0;
        end else if (sel_run != `DPMB_REACT_CYCLES) begin
          sel_run <= sel_run + 2'h1;
        end
      end

      // Alert: pending shift gives the second edge; hold off after a pulse
      always_ff @(posedge clock) begin
        if (srst) begin
          pend <= 2'h0;
          pulse_done <= 1'b0;
        end else begin
          // Both-write clashes alert both ports, a read clash only the reader
          pend <= {pend[0], col_any[p]};
          pulse_done <= pend[1] && !pulse_done;
        end
      end

      always_ff @(posedge clock) begin
        if (srst) begin
          rsp[p] <= '0;
          rsp[p].overlap_alert_n <= 1'b1;
        end else begin
          rsp[p].overlap_alert_n <= !(pend[1] && !pulse_done);
          rsp[p].asleep <= (power == DPMB_SLEEPING);
          // Output drive needs two selected cycles, never while asleep
          rsp[p].data_oe <= acc[p] && req[p].read_mode && (sel_run == `DPMB_REACT_CYCLES);
          rsp[p].read_valid <= acc[p] && req[p].read_mode && !s2;
          if (acc[p] && req[p].read_mode)
            rsp[p].read_data <= mem[req[p].address[IDX_W-1:0]];
        end
      end
    end
  endgenerate

  // Collision: same full port address, both selected, at least one writing
  logic addr_match;
  assign addr_match = (req[0].address == req[1].address) && acc[0] && acc[1];
  assign col_hit[0] = addr_match && req[0].read_mode && !req[1].read_mode;
  assign col_hit[1] = addr_match && req[1].read_mode && !req[0].read_mode;
  logic both_write;
  assign both_write = addr_match && !req[0].read_mode && !req[1].read_mode;

  assign col_any = col_hit | {both_write, both_write};

  // Writes: right port wins a same-word clash, either result is allowed
  always_ff @(posedge clock) begin
    if (acc[0] && !req[0].read_mode)
      mem[req[0].address[IDX_W-1:0]] <= req[0].write_data;
    if (acc[1] && !req[1].read_mode)
      mem[req[1].address[IDX_W-1:0]] <= req[1].write_data;
  end

  logic set_left;
  logic clr_left;
  logic set_right;
  logic clr_right;
  assign set_left = acc[1] && !req[1].read_mode && req[1].address == `DPMB_MBOX_LEFT;
  assign clr_left = acc[0] && req[0].read_mode && req[0].address == `DPMB_MBOX_LEFT;
  assign set_right = acc[0] && !req[0].read_mode && req[0].address == `DPMB_MBOX_RIGHT;
  assign clr_right = acc[1] && req[1].read_mode && req[1].address == `DPMB_MBOX_RIGHT;

  // Set wins over clear; flags deasserted at reset
  always_ff @(posedge clock) begin
    if (srst) begin
      left_doorbell_n <= 1'b1;
    end else if (set_left) begin
      left_doorbell_n <= 1'b0;
    end else if (clr_left) begin
      left_doorbell_n <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      right_doorbell_n <= 1'b1;
    end else if (set_right) begin
      right_doorbell_n <= 1'b0;
    end else if (clr_right) begin
      right_doorbell_n <= 1'b1;
    end
  end

endmodule : dpmb_mailbox
`default_nettype wire

// ### verif/dpmb_host.sv
/* Host model for one port: single or held accesses and the sleep pin.
   Assumes it shares the block's clock. */
`timescale 1ns/1ns
`default_nettype none
module dpmb_host (
  input wire logic clock,
  output dpmb_pkg::dpmb_port_req_type req,
  output var logic sleep_request
);
  import dpmb_pkg::*;
  initial begin
    req = '{1'b1, 1'b0, 1'b1, 18'h00000, 36'h0};
    sleep_request = 1'b0;
  end
  task acc(input logic rd, input logic [17:0] a, input logic [35:0] d, input int n = 1);
    @(posedge clock);
    #1 req = '{1'b0, 1'b1, rd, a, d};
    repeat (n) @(posedge clock);
    // Idle in read mode with the released bus inverted
    #1 req = '{1'b1, 1'b0, 1'b1, ~a, ~d};
  endtask : acc
  task zz(input logic v);
    sleep_request = v;
  endtask : zz
endmodule : dpmb_host
`default_nettype wire

// ### verif/dpmb_checker.sv
/* Port checker for the mailbox block; bound to the top module below. */
`timescale 1ns/1ns
`default_nettype none
module dpmb_checker (
  input wire logic clock,
  input wire logic srst,
  input wire dpmb_pkg::dpmb_port_req_type left_req,
  input wire dpmb_pkg::dpmb_port_req_type right_req,
  input wire logic left_sleep_request,
  input wire logic right_sleep_request,
  input wire dpmb_pkg::dpmb_port_rsp_type left_rsp,
  input wire dpmb_pkg::dpmb_port_rsp_type right_rsp,
  input wire logic left_doorbell_n,
  input wire logic right_doorbell_n
);
  import dpmb_pkg::*;
  logic col_q;
  wire logic ls = !left_req.primary_select_n && left_req.secondary_select && !left_rsp.asleep;
  wire logic rs = !right_req.primary_select_n && right_req.secondary_select;
  wire logic hit = ls && rs && left_req.address == right_req.address;
  wire logic lset = rs && !right_req.read_mode && right_req.address == 18'h3FFFE;
  wire logic lrd = left_req.read_mode;
  wire logic rrd = right_req.read_mode;
  always_ff @(posedge clock) col_q <= hit && !(lrd && rrd);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_fresh; hit && !col_q; endsequence
  sequence s_pulse; !left_rsp.overlap_alert_n ##1 left_rsp.overlap_alert_n; endsequence
  property p_lset; lset |=> !left_doorbell_n; endproperty
  property p_lclr; ls && lrd && left_req.address == 18'h3FFFE && !lset |=> left_doorbell_n;
  endproperty
  property p_rset; ls && !lrd && left_req.address == 18'h3FFFF |=> !right_doorbell_n;
  endproperty
  property p_pulse; $fell(left_rsp.overlap_alert_n) |-> s_pulse; endproperty
  property p_rr; hit && lrd && rrd |-> ##3 left_rsp.overlap_alert_n && right_rsp.overlap_alert_n;
  endproperty
  property p_rw; s_fresh ##0 lrd && !rrd |-> ##3 !left_rsp.overlap_alert_n ##0 right_rsp.overlap_alert_n;
  endproperty
  property p_ww; s_fresh ##0 !lrd && !rrd |-> ##3 !left_rsp.overlap_alert_n && !right_rsp.overlap_alert_n;
  endproperty
  property p_oe; left_rsp.data_oe |-> $past(ls) && $past(ls, 2); endproperty
  property p_zz; left_rsp.asleep |-> !left_rsp.data_oe && !left_rsp.read_valid; endproperty
  property p_zzin; left_sleep_request [*5] |-> left_rsp.asleep; endproperty
  a_lset: assert property (p_lset) else $error("left doorbell not set");
  a_lclr: assert property (p_lclr) else $error("left doorbell not cleared");
  a_rset: assert property (p_rset) else $error("right doorbell not set");
  a_pulse: assert property (p_pulse) else $error("alert not one cycle");
  a_rr: assert property (p_rr) else $error("alert on double read");
  a_rw: assert property (p_rw) else $error("reader alert wrong");
  a_ww: assert property (p_ww) else $error("double write alert missing");
  a_oe: assert property (p_oe) else $error("outputs on too early");
  a_zz: assert property (p_zz) else $error("asleep port active");
  a_zzin: assert property (p_zzin) else $error("sleep not reached");
endmodule : dpmb_checker
bind dpmb_mailbox dpmb_checker u_chk (.clock(clock), .srst(srst), .left_req(left_req),
  .right_req(right_req), .left_sleep_request(left_sleep_request),
  .right_sleep_request(right_sleep_request), .left_rsp(left_rsp), .right_rsp(right_rsp),
  .left_doorbell_n(left_doorbell_n), .right_doorbell_n(right_doorbell_n));
`default_nettype wire

// ### verif/test_dpmb_mailbox.sv
/* Directed bench for the mailbox block; assumes two host models. */
`timescale 1ns/1ns
`default_nettype none
module test_dpmb_mailbox;
  import dpmb_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic lz, rz, ldb, rdb;
  int errors = 0;
  int checked = 0;
  dpmb_port_req_type lq, rq;
  dpmb_port_rsp_type lp, rp;
  always #50 clock = ~clock;
  dpmb_host lh (.clock(clock), .req(lq), .sleep_request(lz));
  dpmb_host rh (.clock(clock), .req(rq), .sleep_request(rz));
  dpmb_mailbox dut (.clock(clock), .srst(srst), .left_req(lq), .right_req(rq),
    .left_sleep_request(lz), .right_sleep_request(rz), .left_rsp(lp), .right_rsp(rp),
    .left_doorbell_n(ldb), .right_doorbell_n(rdb));
  task chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task waitc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : waitc
  task test_done;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  initial begin
    #1000000;
    errors++;
    test_done;
  end
  initial begin
    waitc(8);
    srst = 1'b0;
    chk(ldb, 1'b1);
    rh.acc(1'b0, 18'h3FFFE, 36'hA5A5A5A5A);
    chk(ldb, 1'b0);
    lh.acc(1'b1, 18'h3FFFE, 36'h0);
    chk(ldb, 1'b1);
    chk(lp.read_data, 36'hA5A5A5A5A);
    lh.acc(1'b0, 18'h3FFFF, 36'h123456789);
    chk(rdb, 1'b0);
    rh.acc(1'b1, 18'h3FFFF, 36'h0);
    chk(rdb, 1'b1);
    chk(rp.read_data, 36'h123456789);
    fork lh.acc(1'b1, 18'h00005, 36'h0); rh.acc(1'b0, 18'h00005, 36'h5); join
    waitc(2);
    chk({lp.overlap_alert_n, rp.overlap_alert_n}, 2'h1);
    waitc(1);
    chk(lp.overlap_alert_n, 1'b1);
    fork lh.acc(1'b0, 18'h00006, 36'h6); rh.acc(1'b0, 18'h00006, 36'h6); join
    waitc(2);
    chk({lp.overlap_alert_n, rp.overlap_alert_n}, 2'h0);
    fork lh.acc(1'b1, 18'h00006, 36'h0); rh.acc(1'b1, 18'h00006, 36'h0); join
    waitc(2);
    chk({lp.overlap_alert_n, rp.overlap_alert_n}, 2'h3);
    fork lh.acc(1'b1, 18'h00005, 36'h0, 4); begin waitc(4); chk(lp.data_oe, 1'b1); end join
    chk(lp.read_data, 36'h5);
    waitc(1);
    chk(lp.data_oe, 1'b0);
    lh.acc(1'b0, 18'h00007, 36'hC);
    waitc(3);
    lh.zz(1'b1);
    waitc(5);
    chk({lp.asleep, lp.data_oe}, 2'h2);
    lh.acc(1'b0, 18'h00007, 36'hD);
    waitc(1);
    lh.zz(1'b0);
    waitc(4);
    lh.acc(1'b1, 18'h00007, 36'h0);
    lh.acc(1'b1, 18'h00007, 36'h0);
    chk(lp.read_data, 36'hC);
    test_done;
  end
endmodule : test_dpmb_mailbox
`default_nettype wire
